// ### rtl/scc_pkg.sv
package scc_pkg;

    // ****************************************************************
    // Oscillator type configuration codes
    // ****************************************************************
    localparam logic [2:0] OSC_LOW_GAIN = 3'h0;
    localparam logic [2:0] OSC_MED_GAIN = 3'h1;
    localparam logic [2:0] OSC_HIGH_GAIN = 3'h2;
    localparam logic [2:0] OSC_EXT_RC = 3'h3;
    localparam logic [2:0] OSC_INTERNAL = 3'h4;
    localparam logic [2:0] OSC_EXT_CLK_LOW = 3'h5;
    localparam logic [2:0] OSC_EXT_CLK_MED = 3'h6;
    localparam logic [2:0] OSC_EXT_CLK_HIGH = 3'h7;

    // ****************************************************************
    // Control field codes and reset values
    // ****************************************************************
    localparam logic [1:0] SCS_CONFIG = 2'h0;
    localparam logic [1:0] SCS_TIMEKEEP = 2'h1;
    localparam int SCS_INTERNAL_BIT = 1;
    localparam logic [3:0] INTERNAL_FREQUENCY_SELECT_RESET = 4'h7;
    localparam int INTERNAL_FREQUENCY_SELECT_HF_BIT = 3;
    localparam logic [2:0] INTERNAL_FREQUENCY_SELECT_LF_CODE = 3'h0;
    localparam logic [5:0] TUNE_RESET = 6'h00;
    localparam logic [5:0] TUNE_MAX = 6'h1f;
    localparam logic [5:0] TUNE_MIN = 6'h20;

    // ****************************************************************
    // Counts and timing
    // ****************************************************************
    localparam logic [10:0] STARTUP_OSC_EDGES = 11'h400;
    localparam int CORE_CLK_MHZ = 100;
    localparam int TUNE_STEP_NS = 1000;
    localparam int TUNE_STEP_CYC = (TUNE_STEP_NS * CORE_CLK_MHZ) / 1000;
    localparam logic [6:0] TUNE_STEP_LAST = 7'(TUNE_STEP_CYC - 1);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [2:0] osc_type;
        logic pll_cfg;
        logic clkout_cfg;
        logic power_up_delay_timer_cfg;
    } scc_cfg_t;

    typedef struct packed {
        logic multiplier_soft_enable;
        logic [3:0] internal_frequency_select;
        logic [1:0] system_clock_select;
    } scc_ctrl_t;

    typedef struct packed {
        logic hf_ready;
        logic hf_locked;
        logic hf_stable;
        logic mf_ready;
        logic lf_ready;
    } scc_stat_t;

    typedef enum logic [2:0] {
        SRC_PRIMARY = 3'h0,
        SRC_TIMEKEEP = 3'h1,
        SRC_HF = 3'h2,
        SRC_MF = 3'h3,
        SRC_LF = 3'h4
    } scc_src_t;

    typedef enum logic [1:0] {
        PIN_OSC = 2'h0,
        PIN_GPIO = 2'h1,
        PIN_CLKOUT = 2'h2
    } scc_pin_t;

    typedef enum logic [3:0] {
        ST_WAIT_POWER_UP_DELAY_TIMER = 4'h1,
        ST_COUNT = 4'h2,
        ST_RUN = 4'h4,
        ST_SLEEP = 4'h8
    } scc_state_t;

    function automatic logic is_crystal(input logic [2:0] osc_type);
        return (osc_type == OSC_LOW_GAIN) || (osc_type == OSC_MED_GAIN) ||
               (osc_type == OSC_HIGH_GAIN);
    endfunction : is_crystal

    function automatic logic is_lf_code(input logic [3:0] internal_frequency_select);
        return internal_frequency_select[3:1] == INTERNAL_FREQUENCY_SELECT_LF_CODE;
    endfunction : is_lf_code

endpackage : scc_pkg

// ### rtl/scc_edge_counter.sv
`timescale 1ns/1ns
`default_nettype none

module scc_edge_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic osc_edge,
    // Result
    output logic done
);

    logic [10:0] cnt_q;
    logic done_q;

    // ****************************************************************
    // Oscillator edge count
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 11'h000;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q <= 11'h000;
            done_q <= 1'b0;
        end else if (osc_edge && !done_q) begin
            cnt_q <= cnt_q + 11'h001;
            if (cnt_q == scc_pkg::STARTUP_OSC_EDGES - 11'h001) begin
                done_q <= 1'b1;
            end
        end
    end

    assign done = done_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_done_full_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(done_q) |-> ($past(cnt_q) == scc_pkg::STARTUP_OSC_EDGES - 11'h001)
                          && $past(osc_edge)
    ) else $error("Start-up count ended early");

    a_start_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        start |=> !done_q && (cnt_q == 11'h000)
    ) else $error("Start did not restart the count");

endmodule : scc_edge_counter

`default_nettype wire

// ### rtl/scc_top.sv
`timescale 1ns/1ns
`default_nettype none

module scc_top (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Configuration word
    input wire scc_pkg::scc_cfg_t CFG,
    // Software control
    input wire logic CTRL_WR,
    input wire scc_pkg::scc_ctrl_t CTRL_WDATA,
    output var scc_pkg::scc_ctrl_t CTRL_RDATA,
    input wire logic TUNE_WR,
    input wire logic [5:0] TUNE_WDATA,
    output logic [5:0] TUNE_RDATA,
    // Power and sleep
    input wire logic POWER_UP_DELAY_TIMER_DONE,
    input wire logic SLEEP_ENTER,
    input wire logic WAKE_EVENT,
    output logic CPU_HOLD,
    // Primary oscillator pin
    input wire logic PRI_OSC_IN,
    // Analog oscillator block
    input wire logic HF_RUNNING,
    input wire logic HF_LOCKED,
    input wire logic HF_STABLE,
    input wire logic MF_RUNNING,
    input wire logic LF_RUNNING,
    input wire logic LF_DEMAND,
    output logic HF_ENABLE,
    output logic MF_ENABLE,
    output logic LF_ENABLE,
    output logic PLL_ENABLE,
    output logic [5:0] TRIM,
    // Clock routing and status
    output var scc_pkg::scc_src_t SYSCLK_SRC,
    output var scc_pkg::scc_pin_t PIN1_FUNC,
    output var scc_pkg::scc_pin_t PIN2_FUNC,
    output var scc_pkg::scc_stat_t OSC_STATUS
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic pri_last_q;
    logic wake_last_q;
    logic power_up_delay_timer_s, wake_s, pri_s, hf_run_s, hf_lock_s, hf_stab_s, mf_run_s, lf_run_s;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {POWER_UP_DELAY_TIMER_DONE, WAKE_EVENT, PRI_OSC_IN, HF_RUNNING,
                        HF_LOCKED, HF_STABLE, MF_RUNNING, LF_RUNNING};
            sync2_q <= sync1_q;
        end
    end

    assign {power_up_delay_timer_s, wake_s, pri_s, hf_run_s, hf_lock_s, hf_stab_s, mf_run_s, lf_run_s} = sync2_q;

    // Primary input must stay below half the core rate or edges are lost
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pri_last_q <= 1'b0;
            wake_last_q <= 1'b0;
        end else begin
            pri_last_q <= pri_s;
            wake_last_q <= wake_s;
        end
    end

    logic pri_rise;
    logic wake_rise;
    assign pri_rise = pri_s && !pri_last_q;
    assign wake_rise = wake_s && !wake_last_q;

    // ****************************************************************
    // Configuration capture
    // ****************************************************************
    scc_pkg::scc_cfg_t cfg_q;
    logic cfg_valid_q;

    // Taken once, one edge after reset release; later changes are ignored
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= '0;
            cfg_valid_q <= 1'b0;
        end else if (!cfg_valid_q) begin
            cfg_q <= CFG;
            cfg_valid_q <= 1'b1;
        end
    end

    logic crystal;
    assign crystal = scc_pkg::is_crystal(cfg_q.osc_type);

    // ****************************************************************
    // Software control and tuning
    // ****************************************************************
    scc_pkg::scc_ctrl_t ctrl_q;
    logic [5:0] tune_q;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q.multiplier_soft_enable <= 1'b0;
            ctrl_q.internal_frequency_select <= scc_pkg::INTERNAL_FREQUENCY_SELECT_RESET;
            ctrl_q.system_clock_select <= scc_pkg::SCS_CONFIG;
        end else if (CTRL_WR) begin
            ctrl_q <= CTRL_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tune_q <= scc_pkg::TUNE_RESET;
        end else if (TUNE_WR) begin
            tune_q <= TUNE_WDATA;
        end
    end

    assign CTRL_RDATA = ctrl_q;
    assign TUNE_RDATA = tune_q;

    // ****************************************************************
    // Trim drift
    // ****************************************************************
    // One LSB per step keeps the oscillator from jumping; there is no done flag
    logic [6:0] step_cnt_q;
    logic [5:0] trim_q;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            step_cnt_q <= 7'h00;
        end else if (step_cnt_q == scc_pkg::TUNE_STEP_LAST) begin
            step_cnt_q <= 7'h00;
        end else begin
            step_cnt_q <= step_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            trim_q <= scc_pkg::TUNE_RESET;
        end else if (step_cnt_q == scc_pkg::TUNE_STEP_LAST) begin
            if ($signed(trim_q) < $signed(tune_q)) begin
                trim_q <= trim_q + 6'h01;
            end else if ($signed(trim_q) > $signed(tune_q)) begin
                trim_q <= trim_q - 6'h01;
            end
        end
    end

    // Trim reaches the high and medium oscillators only
    assign TRIM = trim_q;

    // ****************************************************************
    // Source selection and oscillator enables
    // ****************************************************************
    logic int_sel;
    logic lf_sel;
    logic hf_sel;
    scc_pkg::scc_src_t src_d;

    assign int_sel = ctrl_q.system_clock_select[scc_pkg::SCS_INTERNAL_BIT] ||
                     ((ctrl_q.system_clock_select == scc_pkg::SCS_CONFIG) &&
                      (cfg_q.osc_type == scc_pkg::OSC_INTERNAL));
    assign lf_sel = scc_pkg::is_lf_code(ctrl_q.internal_frequency_select);
    assign hf_sel = ctrl_q.internal_frequency_select[scc_pkg::INTERNAL_FREQUENCY_SELECT_HF_BIT];

    always_comb begin
        if (ctrl_q.system_clock_select == scc_pkg::SCS_TIMEKEEP) begin
            src_d = scc_pkg::SRC_TIMEKEEP;
        end else if (int_sel && lf_sel) begin
            src_d = scc_pkg::SRC_LF;
        end else if (int_sel && hf_sel) begin
            src_d = scc_pkg::SRC_HF;
        end else if (int_sel) begin
            src_d = scc_pkg::SRC_MF;
        end else begin
            src_d = scc_pkg::SRC_PRIMARY;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SYSCLK_SRC <= scc_pkg::SRC_PRIMARY;
            HF_ENABLE <= 1'b0;
            MF_ENABLE <= 1'b0;
            LF_ENABLE <= 1'b0;
            PLL_ENABLE <= 1'b0;
        end else begin
            SYSCLK_SRC <= src_d;
            HF_ENABLE <= int_sel && hf_sel;
            // The high clock is derived from the medium one, so both run
            MF_ENABLE <= int_sel && !lf_sel;
            // Low oscillator also feeds power-up timer, watchdog, monitor
            LF_ENABLE <= (int_sel && lf_sel) || LF_DEMAND;
            PLL_ENABLE <= cfg_q.pll_cfg || ctrl_q.multiplier_soft_enable;
        end
    end

    // ****************************************************************
    // Pin functions
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PIN1_FUNC <= scc_pkg::PIN_OSC;
            PIN2_FUNC <= scc_pkg::PIN_OSC;
        end else begin
            PIN1_FUNC <= (cfg_q.osc_type == scc_pkg::OSC_INTERNAL) ?
                         scc_pkg::PIN_GPIO : scc_pkg::PIN_OSC;
            if (crystal) begin
                PIN2_FUNC <= scc_pkg::PIN_OSC;
            end else begin
                PIN2_FUNC <= cfg_q.clkout_cfg ?
                             scc_pkg::PIN_CLKOUT : scc_pkg::PIN_GPIO;
            end
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // No write path reaches these flags
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            OSC_STATUS <= '0;
        end else begin
            OSC_STATUS.hf_ready <= hf_run_s;
            OSC_STATUS.hf_locked <= hf_run_s && hf_lock_s;
            OSC_STATUS.hf_stable <= hf_run_s && hf_stab_s;
            OSC_STATUS.mf_ready <= mf_run_s;
            OSC_STATUS.lf_ready <= lf_run_s;
        end
    end

    // ****************************************************************
    // Start-up sequencer
    // ****************************************************************
    scc_pkg::scc_state_t state_q;
    scc_pkg::scc_state_t state_d;
    logic count_start;
    logic count_done;
    logic power_up_delay_timer_ok;

    assign power_up_delay_timer_ok = cfg_valid_q && (!cfg_q.power_up_delay_timer_cfg || power_up_delay_timer_s);

    always_comb begin
        state_d = state_q;
        count_start = 1'b0;
        unique case (state_q)
            scc_pkg::ST_WAIT_POWER_UP_DELAY_TIMER: begin
                if (power_up_delay_timer_ok) begin
                    state_d = crystal ? scc_pkg::ST_COUNT : scc_pkg::ST_RUN;
                    count_start = crystal;
                end
            end
            scc_pkg::ST_COUNT: begin
                if (count_done) begin
                    state_d = scc_pkg::ST_RUN;
                end
            end
            scc_pkg::ST_RUN: begin
                if (SLEEP_ENTER) begin
                    state_d = scc_pkg::ST_SLEEP;
                end
            end
            scc_pkg::ST_SLEEP: begin
                if (wake_rise) begin
                    state_d = crystal ? scc_pkg::ST_COUNT : scc_pkg::ST_RUN;
                    count_start = crystal;
                end
            end
            default: begin
                state_d = scc_pkg::ST_WAIT_POWER_UP_DELAY_TIMER;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= scc_pkg::ST_WAIT_POWER_UP_DELAY_TIMER;
        end else begin
            state_q <= state_d;
        end
    end

    assign CPU_HOLD = (state_q != scc_pkg::ST_RUN);

    scc_edge_counter u_startup_cycle_counter (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .start(count_start),
        .osc_edge(pri_rise),
        .done(count_done)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_enter_sleep;
        (state_q == scc_pkg::ST_RUN) && SLEEP_ENTER ##1 (state_q == scc_pkg::ST_SLEEP);
    endsequence

    sequence s_wake_crystal;
        (state_q == scc_pkg::ST_SLEEP) && wake_rise && crystal;
    endsequence

    a_hold_count: assert property (
        (state_q == scc_pkg::ST_COUNT) && !count_done |-> CPU_HOLD ##1 CPU_HOLD
    ) else $error("CPU not held during start-up count");

    a_wake_recount: assert property (
        s_wake_crystal |=> (state_q == scc_pkg::ST_COUNT) && CPU_HOLD ##1 !count_done
    ) else $error("Wake-up did not restart the count");

    a_sleep_holds: assert property (
        s_enter_sleep |-> CPU_HOLD
    ) else $error("CPU not held in sleep");

    a_ext_bypass: assert property (
        (state_q == scc_pkg::ST_WAIT_POWER_UP_DELAY_TIMER) && power_up_delay_timer_ok && !crystal
        |=> (state_q == scc_pkg::ST_RUN) && !CPU_HOLD
    ) else $error("Start-up count not bypassed");

    a_pll_either: assert property (
        cfg_valid_q && (cfg_q.pll_cfg || ctrl_q.multiplier_soft_enable) ##1 cfg_valid_q |-> PLL_ENABLE
    ) else $error("Multiplier not enabled");

    a_pll_soft_ignored: assert property (
        cfg_valid_q && cfg_q.pll_cfg && CTRL_WR && !CTRL_WDATA.multiplier_soft_enable |=> ##1 PLL_ENABLE
    ) else $error("Software cleared a configured multiplier");

    a_ctrl_reset_vals: assert property (
        !cfg_valid_q |-> (ctrl_q.system_clock_select == scc_pkg::SCS_CONFIG) &&
                         (ctrl_q.internal_frequency_select == scc_pkg::INTERNAL_FREQUENCY_SELECT_RESET) && (tune_q == scc_pkg::TUNE_RESET)
    ) else $error("Control not at reset values");

    a_lf_select: assert property (
        ctrl_q.system_clock_select[scc_pkg::SCS_INTERNAL_BIT] && lf_sel |=> (SYSCLK_SRC == scc_pkg::SRC_LF)
    ) else $error("Low clock not selected");

    a_hf_needs_mf: assert property (
        HF_ENABLE |-> MF_ENABLE
    ) else $error("High clock running without medium source");

    a_trim_toward: assert property (
        (trim_q != $past(trim_q)) |-> ($past(trim_q) != $past(tune_q)) &&
            ((trim_q - $past(trim_q) == 6'h01) || ($past(trim_q) - trim_q == 6'h01))
    ) else $error("Trim jumped or moved without cause");

    a_cfg_held: assert property (
        cfg_valid_q ##1 1'b1 |-> (cfg_q == $past(cfg_q))
    ) else $error("Configuration changed while running");

endmodule : scc_top

`default_nettype wire

// ### testbench/scc_xtal_model.sv
`timescale 1ns/1ns
`default_nettype none

// Crystal on the primary pin plus the analog oscillator block status
module scc_xtal_model (
    // Clock
    input wire logic clk,
    // Crystal gate: pin stands still low when not running
    input wire logic osc_run,
    // Oscillator enables from the block
    input wire logic hf_en,
    input wire logic mf_en,
    input wire logic lf_en,
    // Pin and status back to the block
    output logic osc,
    output logic hf_run,
    output logic hf_lock,
    output logic hf_stab,
    output logic mf_run,
    output logic lf_run
);
    logic [3:0] age_q;

    initial osc = 1'b0;
    // Finishes a high phase before stopping, so no runt edge
    always begin
        #30;
        if (osc_run || osc) osc = ~osc;
    end

    // Lock before stable, both only after the loop has run a while
    always_ff @(posedge clk) begin
        hf_run <= hf_en;
        mf_run <= mf_en;
        lf_run <= lf_en;
        age_q <= !hf_en ? 4'h0 : (age_q == 4'hf) ? age_q : age_q + 4'h1;
        hf_lock <= hf_en && (age_q >= 4'h4);
        hf_stab <= hf_en && (age_q >= 4'ha);
    end
endmodule : scc_xtal_model

`default_nettype wire

// ### testbench/scc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module scc_top_tb;
    logic clk, rst_n, ctrl_wr, tune_wr, power_up_delay_timer_done, sleep_enter, wake_event, lf_demand, osc_run;
    scc_pkg::scc_cfg_t cfg;
    scc_pkg::scc_ctrl_t ctrl_wdata, ctrl_rdata;
    logic [5:0] tune_wdata, tune_rdata, trim;
    logic osc, hf_r, hf_l, hf_s, mf_r, lf_r, cpu_hold, hf_en, mf_en, lf_en, pll_en;
    scc_pkg::scc_src_t src;
    scc_pkg::scc_pin_t pin1, pin2;
    scc_pkg::scc_stat_t stat;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    scc_top dut (.CORE_CLK(clk), .RST_N(rst_n), .CFG(cfg), .CTRL_WR(ctrl_wr),
        .CTRL_WDATA(ctrl_wdata), .CTRL_RDATA(ctrl_rdata), .TUNE_WR(tune_wr),
        .TUNE_WDATA(tune_wdata), .TUNE_RDATA(tune_rdata), .POWER_UP_DELAY_TIMER_DONE(power_up_delay_timer_done),
        .SLEEP_ENTER(sleep_enter), .WAKE_EVENT(wake_event), .CPU_HOLD(cpu_hold),
        .PRI_OSC_IN(osc), .HF_RUNNING(hf_r), .HF_LOCKED(hf_l), .HF_STABLE(hf_s),
        .MF_RUNNING(mf_r), .LF_RUNNING(lf_r), .LF_DEMAND(lf_demand), .HF_ENABLE(hf_en),
        .MF_ENABLE(mf_en), .LF_ENABLE(lf_en), .PLL_ENABLE(pll_en), .TRIM(trim),
        .SYSCLK_SRC(src), .PIN1_FUNC(pin1), .PIN2_FUNC(pin2), .OSC_STATUS(stat));

    scc_xtal_model xtal (.clk(clk), .osc_run(osc_run), .hf_en(hf_en), .mf_en(mf_en),
        .lf_en(lf_en), .osc(osc), .hf_run(hf_r), .hf_lock(hf_l), .hf_stab(hf_s),
        .mf_run(mf_r), .lf_run(lf_r));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic start(input logic [2:0] ty, input logic pll, input logic ck, input logic pw);
        @(negedge clk);
        rst_n = 1'b0;
        cfg = {ty, pll, ck, pw};
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : start

    task automatic wr(input logic sp, input logic [3:0] ir, input logic [1:0] sc);
        @(negedge clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = {sp, ir, sc};
        @(negedge clk);
        ctrl_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr

    task automatic run_xtal(input int n);
        osc_run = 1'b1;
        repeat (n) @(posedge osc);
        osc_run = 1'b0;
        repeat (12) @(negedge clk);
    endtask : run_xtal

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_crystal;
        start(scc_pkg::OSC_HIGH_GAIN, 1'b0, 1'b0, 1'b1);
        chk(ctrl_rdata, {1'b0, 4'h7, 2'h0});
        chk(tune_rdata, 8'h00);
        run_xtal(1100);
        chk(cpu_hold, 1'b1);
        power_up_delay_timer_done = 1'b1;
        repeat (10) @(negedge clk);
        run_xtal(1023);
        chk(cpu_hold, 1'b1);
        run_xtal(1);
        chk(cpu_hold, 1'b0);
        sleep_enter = 1'b1;
        @(negedge clk);
        sleep_enter = 1'b0;
        wake_event = 1'b1;
        repeat (10) @(negedge clk);
        chk(cpu_hold, 1'b1);
        run_xtal(1024);
        chk(cpu_hold, 1'b0);
        wake_event = 1'b0;
    endtask : t_crystal

    task automatic t_pll;
        start(scc_pkg::OSC_EXT_CLK_HIGH, 1'b0, 1'b1, 1'b0);
        chk(cpu_hold, 1'b0);
        chk(pll_en, 1'b0);
        wr(1'b1, 4'h7, 2'h0);
        chk(pll_en, 1'b1);
        cfg = {scc_pkg::OSC_EXT_CLK_HIGH, 1'b1, 1'b1, 1'b0};
        wr(1'b0, 4'h7, 2'h0);
        chk(pll_en, 1'b0);
        start(scc_pkg::OSC_EXT_CLK_HIGH, 1'b1, 1'b1, 1'b0);
        wr(1'b0, 4'h7, 2'h0);
        chk(pll_en, 1'b1);
    endtask : t_pll

    task automatic t_sources;
        start(scc_pkg::OSC_EXT_RC, 1'b0, 1'b0, 1'b0);
        chk({pin1, pin2}, {scc_pkg::PIN_OSC, scc_pkg::PIN_GPIO});
        chk(src, scc_pkg::SRC_PRIMARY);
        wr(1'b0, 4'h7, 2'h2);
        chk({mf_en, hf_en, src}, {2'b10, scc_pkg::SRC_MF});
        start(scc_pkg::OSC_INTERNAL, 1'b0, 1'b1, 1'b0);
        chk({pin1, pin2}, {scc_pkg::PIN_GPIO, scc_pkg::PIN_CLKOUT});
        chk(src, scc_pkg::SRC_MF);
        lf_demand = 1'b1;
        wr(1'b0, 4'hf, 2'h0);
        repeat (20) @(negedge clk);
        chk({hf_en, mf_en, src}, {2'b11, scc_pkg::SRC_HF});
        chk(stat, 5'h1f);
        lf_demand = 1'b0;
        wr(1'b0, 4'h0, 2'h2);
        chk({lf_en, hf_en, src}, {2'b10, scc_pkg::SRC_LF});
        wr(1'b0, 4'h0, 2'h1);
        chk(src, scc_pkg::SRC_TIMEKEEP);
    endtask : t_sources

    task automatic t_tune;
        @(negedge clk);
        tune_wr = 1'b1;
        tune_wdata = 6'h1f;
        @(negedge clk);
        tune_wr = 1'b0;
        tune_wdata = 6'h20;
        chk(tune_rdata, 6'h1f);
        chk(trim == 6'h1f, 1'b0);
        repeat (3220) @(negedge clk);
        chk(trim, 6'h1f);
        tune_wr = 1'b1;
        @(negedge clk);
        tune_wr = 1'b0;
        repeat (6420) @(negedge clk);
        chk(trim, 6'h20);
    endtask : t_tune

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        ctrl_wr = 1'b0;
        ctrl_wdata = '0;
        tune_wr = 1'b0;
        tune_wdata = '0;
        power_up_delay_timer_done = 1'b0;
        sleep_enter = 1'b0;
        wake_event = 1'b0;
        lf_demand = 1'b0;
        osc_run = 1'b0;
        t_crystal();
        t_pll();
        t_sources();
        t_tune();
        results();
    end
endmodule : scc_top_tb

`default_nettype wire
